// ===== rtl/stx_cfg.svh
`ifndef STX_CFG_SVH
`define STX_CFG_SVH

// ========
// register offsets (byte addresses)
`define STX_OFF_OFFTIME 8'h00
`define STX_OFF_STATUS 8'h04
`define STX_OFF_IRQ_STAT 8'h08
`define STX_OFF_IRQ_CLR 8'h0C
`define STX_OFF_IRQ_EN 8'h10

// ========
// timing
`define STX_CLK_PERIOD_NS 100
`define STX_OFF_TIME_NS 30000
`define STX_OFF_CYCLES (`STX_OFF_TIME_NS / `STX_CLK_PERIOD_NS)
// fast share of the off-time is 5/16 = 31.25 %
`define STX_FAST_NUM 5
`define STX_FAST_SHIFT 4

// ========
// translator
`define STX_HOME_POS 3'h1
`define STX_LVL_ZERO 2'h0
`define STX_LVL_MID 2'h1
`define STX_LVL_FULL 2'h2

// ========
// interrupt bit positions
`define STX_IRQ_STEP 0
`define STX_IRQ_FAULT 1
`define STX_IRQ_TRIP1 2
`define STX_IRQ_TRIP2 3
`define STX_IRQ_W 4

`define STX_RESP_OKAY 2'h0
`define STX_RESP_SLVERR 2'h2

`endif

// ===== rtl/stx_chopper.sv
`timescale 1ns/100ps
`include "stx_cfg.svh"

// fixed off-time chopper for one bridge
module stx_chopper #(
    parameter int OFF_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic trip,
    input wire logic mixed,
    input wire logic zero_current,
    input wire logic [OFF_W-1:0] off_len,
    output stx_pkg::stx_chop_e mode_q,
    output logic zero_seen_q
);

    logic [OFF_W-1:0] cnt_q;
    logic [OFF_W-1:0] fast_len;
    logic [OFF_W+3:0] prod;

    // fast part is the off-time scaled by 5/16
    assign prod = {4'h0, off_len} * (OFF_W+4)'(`STX_FAST_NUM);
    assign fast_len = prod[OFF_W+3:`STX_FAST_SHIFT];

    // ========
    // decay sequencing
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_q <= stx_pkg::STX_CHOP_ON;
            cnt_q <= '0;
        end else begin
            case (mode_q)
                stx_pkg::STX_CHOP_ON: begin
                    cnt_q <= '0;
                    if (trip) begin
                        // a zero fast share degenerates to plain slow decay
                        if (mixed && fast_len != '0) begin
                            mode_q <= stx_pkg::STX_CHOP_FAST;
                        end else begin
                            mode_q <= stx_pkg::STX_CHOP_SLOW;
                        end
                    end
                end
                stx_pkg::STX_CHOP_FAST: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q + 1'b1 >= fast_len) begin
                        mode_q <= stx_pkg::STX_CHOP_SLOW;
                    end
                end
                stx_pkg::STX_CHOP_SLOW: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q + 1'b1 >= off_len) begin
                        mode_q <= stx_pkg::STX_CHOP_ON;
                    end
                end
                default: begin
                    mode_q <= stx_pkg::STX_CHOP_ON;
                end
            endcase
        end
    end

    // zero current latched for the rest of the off-time
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            zero_seen_q <= 1'b0;
        end else if (mode_q == stx_pkg::STX_CHOP_ON) begin
            zero_seen_q <= 1'b0;
        end else if (zero_current) begin
            zero_seen_q <= 1'b1;
        end
    end

endmodule // stx_chopper

// ===== rtl/stx_pkg.sv
package stx_pkg;

    typedef enum logic [1:0] {
        STX_CHOP_ON,
        STX_CHOP_FAST,
        STX_CHOP_SLOW
    } stx_chop_e;

    // gate drives of one full bridge
    typedef struct packed {
        logic src_a;
        logic snk_a;
        logic src_b;
        logic snk_b;
    } stx_bridge_s;

    // translator output for one phase
    typedef struct packed {
        logic neg;
        logic [1:0] level;
    } stx_phase_s;

endpackage

// ===== rtl/stx_translator.sv
`timescale 1ns/100ps
`include "stx_cfg.svh"

module stx_translator #(
    parameter int OFF_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic step,
    input wire logic dir,
    input wire logic resolution_select,
    input wire logic trans_reset_n,
    input wire logic out_disable,
    input wire logic overtemp,
    input wire logic gate_reservoir_uv,
    input wire logic sink_gate_regulator_fault,
    input wire logic undervoltage_lockout,
    input wire logic [1:0] trip,
    input wire logic [1:0] zero_current,
    output stx_pkg::stx_bridge_s bridge1_q,
    output stx_pkg::stx_bridge_s bridge2_q,
    output stx_pkg::stx_phase_s phase1_q,
    output stx_pkg::stx_phase_s phase2_q,
    output logic [1:0] mixed_q,
    output logic irq_q,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ========
    // level table
    function automatic stx_pkg::stx_phase_s phase_of(input logic [2:0] pos, input logic second);
        logic [2:0] p;
        stx_pkg::stx_phase_s r;
        p = second ? pos - 3'h2 : pos; // phase 2 lags phase 1 by two positions
        r.neg = (p == 3'h3) || (p == 3'h4) || (p == 3'h5);
        case (p)
            3'h0, 3'h4: r.level = `STX_LVL_FULL;
            3'h2, 3'h6: r.level = `STX_LVL_ZERO;
            default: r.level = `STX_LVL_MID;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = val[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic [2:0] pos_q;
    logic [2:0] pos_d;
    logic step_s1_q;
    logic step_s2_q;
    logic step_s3_q;
    logic step_rise;
    logic home_hold;
    logic kill;
    logic kill_q;
    logic [OFF_W-1:0] off_len_q;
    logic [`STX_IRQ_W-1:0] irq_stat_q;
    logic [`STX_IRQ_W-1:0] irq_en_q;
    logic [`STX_IRQ_W-1:0] irq_set;
    logic [`STX_IRQ_W-1:0] irq_clr;
    stx_pkg::stx_chop_e chop_mode [2];
    logic [1:0] zero_seen;
    stx_pkg::stx_phase_s new1;
    stx_pkg::stx_phase_s new2;

    // ========
    // step synchroniser; only the second and third stages feed the edge detect
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            step_s1_q <= 1'b0;
            step_s2_q <= 1'b0;
            step_s3_q <= 1'b0;
        end else begin
            step_s1_q <= step;
            step_s2_q <= step_s1_q;
            step_s3_q <= step_s2_q;
        end
    end

    assign step_rise = step_s2_q && !step_s3_q;
    assign home_hold = !trans_reset_n || undervoltage_lockout;
    // output kill collects every shutdown source
    assign kill = out_disable || overtemp || gate_reservoir_uv
                  || sink_gate_regulator_fault || home_hold;

    // ========
    // next position: full step lands on even half-step numbers (odd indices)
    always_comb begin
        if (resolution_select || !pos_q[0]) begin
            pos_d = dir ? pos_q + 3'h1 : pos_q - 3'h1;
        end else begin
            pos_d = dir ? pos_q + 3'h2 : pos_q - 3'h2;
        end
    end

    assign new1 = phase_of(pos_d, 1'b0);
    assign new2 = phase_of(pos_d, 1'b1);

    // translator state; unaffected by the disable input
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pos_q <= `STX_HOME_POS;
            phase1_q <= phase_of(`STX_HOME_POS, 1'b0);
            phase2_q <= phase_of(`STX_HOME_POS, 1'b1);
            mixed_q <= 2'h3;
        end else if (home_hold) begin
            pos_q <= `STX_HOME_POS;
            phase1_q <= phase_of(`STX_HOME_POS, 1'b0);
            phase2_q <= phase_of(`STX_HOME_POS, 1'b1);
            mixed_q <= 2'h3;
        end else if (step_rise) begin
            pos_q <= pos_d;
            phase1_q <= new1;
            phase2_q <= new2;
            mixed_q[0] <= new1.level < phase1_q.level;
            mixed_q[1] <= new2.level < phase2_q.level;
        end
    end

    // ========
    // off-time choppers
    for (genvar g = 0; g < 2; g++) begin : g_chop
        stx_chopper #(
            .OFF_W(OFF_W)
        ) u_chop (
            .clk(clk),
            .reset_n(reset_n),
            .trip(trip[g] && !kill),
            .mixed(mixed_q[g]),
            .zero_current(zero_current[g]),
            .off_len(off_len_q),
            .mode_q(chop_mode[g]),
            .zero_seen_q(zero_seen[g])
        );
    end

    function automatic stx_pkg::stx_bridge_s drive(input stx_pkg::stx_phase_s ph,
                                                   input stx_pkg::stx_chop_e m,
                                                   input logic zs, input logic off);
        stx_pkg::stx_bridge_s b;
        logic fwd_src;
        logic fwd_snk;
        logic rev_src;
        logic rev_snk;
        fwd_src = 1'b0;
        fwd_snk = 1'b0;
        rev_src = 1'b0;
        rev_snk = 1'b0;
        if (!off && ph.level != `STX_LVL_ZERO) begin
            case (m)
                stx_pkg::STX_CHOP_ON: begin
                    fwd_src = 1'b1;
                    fwd_snk = 1'b1;
                end
                stx_pkg::STX_CHOP_FAST: begin
                    rev_src = !zs;
                    rev_snk = !zs;
                end
                stx_pkg::STX_CHOP_SLOW: begin
                    fwd_snk = !zs;
                    rev_snk = !zs;
                end
                default: begin
                    fwd_src = 1'b0;
                end
            endcase
        end
        // forward diagonal is source A to sink B for positive current
        b.src_a = ph.neg ? rev_src : fwd_src;
        b.snk_b = ph.neg ? rev_snk : fwd_snk;
        b.src_b = ph.neg ? fwd_src : rev_src;
        b.snk_a = ph.neg ? fwd_snk : rev_snk;
        return b;
    endfunction

    // gates registered so every pin comes from a flip-flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bridge1_q <= '0;
            bridge2_q <= '0;
        end else begin
            bridge1_q <= drive(phase1_q, chop_mode[0], zero_seen[0], kill);
            bridge2_q <= drive(phase2_q, chop_mode[1], zero_seen[1], kill);
        end
    end

    // ========
    // interrupts: set wins over a simultaneous clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            kill_q <= 1'b1;
        end else begin
            kill_q <= overtemp || gate_reservoir_uv || sink_gate_regulator_fault
                      || undervoltage_lockout;
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[`STX_IRQ_STEP] = step_rise && !home_hold;
        irq_set[`STX_IRQ_FAULT] = !kill_q && (overtemp || gate_reservoir_uv
                                  || sink_gate_regulator_fault || undervoltage_lockout);
        irq_set[`STX_IRQ_TRIP1] = trip[0] && chop_mode[0] == stx_pkg::STX_CHOP_ON && !kill;
        irq_set[`STX_IRQ_TRIP2] = trip[1] && chop_mode[1] == stx_pkg::STX_CHOP_ON && !kill;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_q <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
        end
    end

    // ========
    // AXI4-Lite write: address and data taken in either order
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [31:0] cur;

    assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
    assign irq_clr = (do_write && waddr_q == `STX_OFF_IRQ_CLR && wstrb_q[0])
                     ? wdata_q[`STX_IRQ_W-1:0] : '0;
    assign cur = merge({{(32-OFF_W){1'b0}}, off_len_q}, wdata_q, wstrb_q);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `STX_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                waddr_q <= {s_axi_awaddr[7:2], 2'h0};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (waddr_q)
                    `STX_OFF_OFFTIME, `STX_OFF_IRQ_CLR, `STX_OFF_IRQ_EN,
                    `STX_OFF_STATUS, `STX_OFF_IRQ_STAT: s_axi_bresp <= `STX_RESP_OKAY;
                    default: s_axi_bresp <= `STX_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // writable registers; status registers ignore writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            off_len_q <= OFF_W'(`STX_OFF_CYCLES);
            irq_en_q <= '0;
        end else if (do_write) begin
            if (waddr_q == `STX_OFF_OFFTIME && cur[OFF_W-1:0] != '0) begin
                off_len_q <= cur[OFF_W-1:0]; // a zero length would end the off-time after one slow cycle
            end
            if (waddr_q == `STX_OFF_IRQ_EN && wstrb_q[0]) begin
                irq_en_q <= wdata_q[`STX_IRQ_W-1:0];
            end
        end
    end

    // ========
    // AXI4-Lite read: one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `STX_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `STX_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
                `STX_OFF_OFFTIME: s_axi_rdata <= 32'(off_len_q);
                `STX_OFF_STATUS: s_axi_rdata <= {16'h0, 1'(kill), mixed_q,
                    2'(chop_mode[1]), 2'(chop_mode[0]), phase2_q, phase1_q, pos_q};
                `STX_OFF_IRQ_STAT: s_axi_rdata <= 32'(irq_stat_q);
                `STX_OFF_IRQ_EN: s_axi_rdata <= 32'(irq_en_q);
                `STX_OFF_IRQ_CLR: s_axi_rdata <= 32'h0;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `STX_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // stx_translator

// ===== verification/stx_host_model.sv
`timescale 1ns/100ps
// ========
// host controller issuing step pulses
module stx_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic go_dir,
    input wire logic go_res,
    input wire logic [3:0] hold,
    output logic step = 1'b0,
    output logic dir = 1'b0,
    output logic resolution_select = 1'b0,
    output logic busy = 1'b0
);
    logic [4:0] cnt_q = 5'h00;
    // dir and resolution settle three cycles before the rise; hold sets prompt or slow pulses
    always_ff @(posedge clk) begin
        if (go && !busy) begin
            dir <= go_dir;
            resolution_select <= go_res;
            busy <= 1'b1;
            cnt_q <= 5'h00;
        end else if (busy) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h02) step <= 1'b1;
            if (cnt_q == {1'b0, hold} + 5'h02) step <= 1'b0;
            if (cnt_q == {hold, 1'b0} + 5'h02) busy <= 1'b0;
        end
    end
endmodule // stx_host_model

// ===== verification/stx_translator_props.sv
`timescale 1ns/100ps
// ========
// port checker for the translator
module stx_translator_props #(
    parameter int OFF_W = 16,
    parameter int FAST_LEN = 5 // fast share of the 16-cycle off-time the bench programs
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic step,
    input wire logic trans_reset_n,
    input wire logic out_disable,
    input wire logic overtemp,
    input wire logic gate_reservoir_uv,
    input wire logic sink_gate_regulator_fault,
    input wire logic undervoltage_lockout,
    input wire stx_pkg::stx_bridge_s bridge1_q,
    input wire stx_pkg::stx_bridge_s bridge2_q,
    input wire stx_pkg::stx_phase_s phase1_q,
    input wire stx_pkg::stx_phase_s phase2_q,
    input wire logic [1:0] mixed_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic gates_off;
    logic run_ok;
    logic fast1;
    logic [7:0] fast_cnt_q;
    // helper levels; a fresh negative phase shows its old on-diagonal for one cycle only
    assign gates_off = (bridge1_q == 4'h0) && (bridge2_q == 4'h0);
    assign run_ok = trans_reset_n && !undervoltage_lockout;
    assign fast1 = phase1_q.neg ? (bridge1_q == 4'h9) : (bridge1_q == 4'h6);
    // counts consecutive fast-decay cycles on bridge 1
    always_ff @(posedge clk) begin
        if (!reset_n || !fast1) begin
            fast_cnt_q <= 8'h00;
        end else if (fast_cnt_q != 8'hFF) begin
            fast_cnt_q <= fast_cnt_q + 8'h01;
        end
    end
    // ========
    // sequences
    sequence step_rise_s;
        $rose(step) && run_ok;
    endsequence
    sequence moved_s;
        $changed(phase1_q) || $changed(phase2_q);
    endsequence
    // ========
    // assertions
    chk_disable_kill: assert property (out_disable [*3] |-> gates_off)
        else $error("gates on while disabled");
    chk_fault_kill: assert property ((overtemp || gate_reservoir_uv) [*3] |-> gates_off)
        else $error("gates on during fault");
    chk_regulator_kill: assert property (sink_gate_regulator_fault [*3] |-> gates_off)
        else $error("gates on during regulator fault");
    chk_lockout_home: assert property (undervoltage_lockout [*3] |->
        gates_off && phase1_q == 3'h1 && phase2_q == 3'h1)
        else $error("lockout did not go home");
    chk_reset_home: assert property (!trans_reset_n [*3] |->
        gates_off && phase1_q == 3'h1 && phase2_q == 3'h1)
        else $error("translator reset did not go home");
    chk_step_moves: assert property (step_rise_s |-> ##[2:6] moved_s)
        else $error("step edge did not move");
    chk_step_once: assert property ((moved_s ##0 run_ok) |=>
        (!$changed(phase1_q) && !$changed(phase2_q)) [*3])
        else $error("position moved twice");
    chk_decay_pick: assert property ((moved_s ##0 run_ok) |-> mixed_q ==
        {phase2_q.level < $past(phase2_q.level), phase1_q.level < $past(phase1_q.level)})
        else $error("wrong decay choice");
    chk_fast_share: assert property (fast1 |-> fast_cnt_q < FAST_LEN)
        else $error("fast decay too long");
endmodule // stx_translator_props

bind stx_translator stx_translator_props #(.OFF_W(OFF_W)) u_props (
    .clk(clk), .reset_n(reset_n), .step(step), .trans_reset_n(trans_reset_n),
    .out_disable(out_disable), .overtemp(overtemp), .gate_reservoir_uv(gate_reservoir_uv),
    .sink_gate_regulator_fault(sink_gate_regulator_fault),
    .undervoltage_lockout(undervoltage_lockout), .bridge1_q(bridge1_q), .bridge2_q(bridge2_q),
    .phase1_q(phase1_q), .phase2_q(phase2_q), .mixed_q(mixed_q)
);

// ===== verification/tb_stepper_translator_output_control.sv
`timescale 1ns/100ps
`include "stx_cfg.svh"
module tb_stepper_translator_output_control;
    typedef struct packed {
        logic d;
        logic r;
        logic dis;
        logic [2:0] p1;
        logic [2:0] p2;
        logic [1:0] mix;
    } stx_row_s;
    logic clk, reset_n, trans_reset_n, go, go_dir, go_res, busy, step, dir, resolution_select;
    logic irq_q, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] hold, s_axi_wstrb;
    logic [4:0] fault_v;
    logic [1:0] trip, zero_current, mixed_q, s_axi_bresp, s_axi_rresp, r;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    stx_pkg::stx_bridge_s bridge1_q, bridge2_q;
    stx_pkg::stx_phase_s phase1_q, phase2_q;
    int mismatches, n_tests, nf, ns;
    // walk from home: dir, resolution, disable, phase1, phase2, decay select
    stx_row_s rows [10] = '{'{1, 1, 0, 3'h0, 3'h2, 2'h1}, '{1, 1, 1, 3'h5, 3'h1, 2'h2},
        '{1, 0, 0, 3'h5, 3'h5, 2'h0}, '{0, 0, 1, 3'h5, 3'h1, 2'h0}, '{0, 1, 0, 3'h0, 3'h2, 2'h1},
        '{0, 0, 0, 3'h1, 3'h1, 2'h2}, '{0, 1, 0, 3'h2, 3'h0, 2'h2}, '{0, 1, 0, 3'h1, 3'h5, 2'h1},
        '{1, 1, 0, 3'h2, 3'h0, 2'h2}, '{1, 0, 0, 3'h1, 3'h1, 2'h1}};

    stx_translator dut (.clk(clk), .reset_n(reset_n), .step(step), .dir(dir),
        .resolution_select(resolution_select), .trans_reset_n(trans_reset_n),
        .out_disable(fault_v[0]), .overtemp(fault_v[1]), .gate_reservoir_uv(fault_v[2]),
        .sink_gate_regulator_fault(fault_v[3]), .undervoltage_lockout(fault_v[4]),
        .trip(trip), .zero_current(zero_current), .bridge1_q(bridge1_q), .bridge2_q(bridge2_q),
        .phase1_q(phase1_q), .phase2_q(phase2_q), .mixed_q(mixed_q), .irq_q(irq_q),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    stx_host_model host (.clk(clk), .go(go), .go_dir(go_dir), .go_res(go_res), .hold(hold),
        .step(step), .dir(dir), .resolution_select(resolution_select), .busy(busy));

    // ========
    // clock and helpers
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic test_done;
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang(input string what);
        check_word(what, 32'h1, 32'h0);
        test_done();
    endtask
    // a fresh edge first, so back-to-back calls never assign a signal twice at once
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                check_word("bresp", 32'(er), 32'(s_axi_bresp));
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("bvalid");
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("rvalid");
    endtask
    task automatic do_step(input logic d, input logic rs, input logic [3:0] h);
        go <= 1'b1;
        go_dir <= d;
        go_res <= rs;
        hold <= h;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (int n = 0; busy && n < 40; n++) @(posedge clk);
        if (busy) hang("step");
        repeat (4) @(posedge clk);
    endtask
    task automatic chk_pos(input logic [2:0] p1, input logic [2:0] p2);
        check_word("phase1", 32'(p1), 32'(phase1_q));
        check_word("phase2", 32'(p2), 32'(phase2_q));
    endtask

    // ========
    // main sequence
    initial begin
        {reset_n, go, go_dir, go_res, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h00;
        {s_axi_arvalid, s_axi_rready, trip, zero_current, fault_v} = 11'h000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        trans_reset_n = 1'b1;
        hold = 4'h3;
        s_axi_wstrb = 4'hF;
        mismatches = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        chk_pos(3'h1, 3'h1);
        check_word("mixed", 32'h3, 32'(mixed_q));
        check_word("gates", 32'h0, 32'({bridge1_q, bridge2_q}));
        reset_n <= 1'b1;
        axi_rd(`STX_OFF_OFFTIME);
        check_word("offtime", 32'h0000012C, rd);
        axi_wr(`STX_OFF_OFFTIME, 32'h10, `STX_RESP_OKAY);
        axi_rd(`STX_OFF_OFFTIME);
        check_word("offtime", 32'h10, rd);
        axi_wr(8'h40, 32'h1, `STX_RESP_SLVERR);
        axi_rd(8'h40);
        check_word("rresp", 32'(`STX_RESP_SLVERR), 32'(r));
        axi_wr(`STX_OFF_IRQ_EN, 32'h1, `STX_RESP_OKAY);
        foreach (rows[i]) begin
            fault_v <= {4'h0, rows[i].dis};
            do_step(rows[i].d, rows[i].r, (i % 2) ? 4'h8 : 4'h3);
            chk_pos(rows[i].p1, rows[i].p2);
            check_word("mixed", 32'(rows[i].mix), 32'(mixed_q));
            if (rows[i].dis) check_word("gates", 32'h0, 32'({bridge1_q, bridge2_q}));
        end
        check_word("irq", 32'h1, 32'(irq_q));
        axi_wr(`STX_OFF_IRQ_CLR, 32'h1, `STX_RESP_OKAY);
        axi_wr(`STX_OFF_IRQ_EN, 32'h0, `STX_RESP_OKAY);
        check_word("irq", 32'h0, 32'(irq_q));
        do_step(1'b0, 1'b1, 4'h3);
        do_step(1'b1, 1'b1, 4'h3);
        axi_rd(`STX_OFF_IRQ_STAT);
        check_word("stat", 32'h1, rd & 32'h1);
        check_word("masked irq", 32'h0, 32'(irq_q));
        check_word("on gates", 32'h99, 32'({bridge1_q, bridge2_q}));
        // mixed decay on phase 1: 5 fast then 11 slow cycles out of 16
        trip <= 2'h1;
        @(posedge clk);
        trip <= 2'h0;
        nf = 0;
        ns = 0;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (bridge1_q == 4'h6) nf++;
            if (bridge1_q == 4'h5) ns++;
        end
        check_word("fast", 32'd5, 32'(nf));
        check_word("slow", 32'd11, 32'(ns));
        trip <= 2'h1;
        @(posedge clk);
        trip <= 2'h0;
        repeat (9) @(posedge clk);
        zero_current <= 2'h1;
        repeat (3) @(posedge clk);
        check_word("rect off", 32'h0, 32'(bridge1_q));
        zero_current <= 2'h0;
        repeat (20) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            do_step(1'b1, 1'b1, 4'h3);
            fault_v <= 5'h01 << k;
            repeat (4) @(posedge clk);
            check_word("gates", 32'h0, 32'({bridge1_q, bridge2_q}));
            if (k == 4) chk_pos(3'h1, 3'h1);
            fault_v <= 5'h00;
            repeat (3) @(posedge clk);
        end
        do_step(1'b1, 1'b1, 4'h3);
        trans_reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        do_step(1'b1, 1'b1, 4'h8);
        chk_pos(3'h1, 3'h1);
        check_word("gates", 32'h0, 32'({bridge1_q, bridge2_q}));
        trans_reset_n <= 1'b1;
        @(posedge clk);
        do_step(1'b1, 1'b1, 4'h3);
        chk_pos(3'h0, 3'h2);
        test_done();
    end
endmodule // tb_stepper_translator_output_control
